// [core/btpg_params.svh]
// constants for the bus transfer protection gate: offsets, field positions, reset values
// assumes inclusion by bare name from the structure memory, structure check and gate files
`ifndef BTPG_PARAMS_SVH
`define BTPG_PARAMS_SVH
`define BTPG_NUM_STRUCT     16
`define BTPG_NUM_FIXED      4
`define BTPG_TOP_IDX        4'hF
`define BTPG_STRUCT_LIMIT   32'h0000_0200
`define BTPG_OFS_CTRL       32'h0000_0200
`define BTPG_OFS_STATUS     32'h0000_0204
`define BTPG_OFS_MASK       32'h0000_0208
`define BTPG_OFS_FAULT_ADDR 32'h0000_020C
`define BTPG_OFS_FAULT_INFO 32'h0000_0210
`define BTPG_ATT_PRIV_BASE  3
`define BTPG_ATT_NS         6
`define BTPG_ATT_PC_LO      8
`define BTPG_ATT_SIZE_LO    24
`define BTPG_ATT_SIZE_HI    28
`define BTPG_ATT_EN         31
`define BTPG_SIZE_MIN       5'h07
`define BTPG_FIXED_SIZE     5'h0B
`define BTPG_FIXED_BASE     32'h4000_0000
`define BTPG_FIXED_STEP     32'h0000_1000
`define BTPG_CTRL_RST       2'h2
`define BTPG_EVT_DENY       0
`define BTPG_EVT_UPSTREAM   1
`endif

// [core/btpg_pkg.sv]
// types shared by the protection gate files
// assumes nothing beyond a SystemVerilog compiler
package btpg_pkg;
    typedef enum logic [1:0] {
        BTPG_MODE_MASTER = 2'b00,
        BTPG_MODE_SHARED = 2'b01,
        BTPG_MODE_PERIPH = 2'b10
    } btpg_mode_t;
    typedef enum logic [1:0] {
        BTPG_ST_IDLE = 2'b00,
        BTPG_ST_SCAN = 2'b01
    } btpg_state_t;
endpackage

// [core/btpg_struct_mem.sv]
// storage of the sixteen protection structures, address and attribute word each
// assumes one writer (the register bus) and two readers, read data one cycle late
`timescale 1ns/1ps
`default_nettype none
`include "btpg_params.svh"
module btpg_struct_mem (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_idx,
    input  wire logic        wr_att,
    input  wire logic [31:0] wr_data,
    // evaluation read port
    input  wire logic [3:0]  ev_idx,
    output var  logic [31:0] ev_addr,
    output var  logic [31:0] ev_att,
    // register bus read port
    input  wire logic [3:0]  bus_idx,
    input  wire logic        bus_att,
    output var  logic [31:0] bus_data
);
    logic [31:0] addr_mem [`BTPG_NUM_STRUCT];
    logic [31:0] att_mem  [`BTPG_NUM_STRUCT];

    // contents clear at reset so every structure starts disabled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `BTPG_NUM_STRUCT; i++) begin
                addr_mem[i] <= 32'h0000_0000;
                att_mem[i]  <= 32'h0000_0000;
            end
            ev_addr  <= 32'h0000_0000;
            ev_att   <= 32'h0000_0000;
            bus_data <= 32'h0000_0000;
        end else begin
            if (wr_en && !wr_att) addr_mem[wr_idx] <= wr_data;
            if (wr_en && wr_att)  att_mem[wr_idx]  <= wr_data;
            ev_addr  <= addr_mem[ev_idx];
            ev_att   <= att_mem[ev_idx];
            bus_data <= bus_att ? att_mem[bus_idx] : addr_mem[bus_idx];
        end
    end
endmodule
`default_nettype wire

// [core/btpg_struct_check.sv]
// region match and attribute check of one protection structure against one transfer
// assumes structure words already carry any fixed-region override; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "btpg_params.svh"
module btpg_struct_check (
    // structure words
    input  wire logic [31:0]         addr_word,
    input  wire logic [31:0]         att_word,
    // transfer
    input  wire logic [31:0]         req_addr,
    input  wire logic                req_write,
    input  wire logic                req_exec,
    input  wire logic                req_priv,
    input  wire logic                req_secure,
    input  wire logic [3:0]          req_pc,
    input  wire btpg_pkg::btpg_mode_t mode,
    // verdict
    output var  logic                hit,
    output var  logic                permit
);
    import btpg_pkg::*;

    // ones below the region boundary; 33 bits so a 4 GB region does not overflow
    function automatic logic [31:0] region_mask(input logic [4:0] size);
        logic [32:0] m;
        m = (33'h1 << ({1'b0, size} + 6'h01)) - 33'h1;
        return m[31:0];
    endfunction

    logic [4:0]  size;
    logic [31:0] mask;
    logic [2:0]  sub;
    logic        col_priv;
    logic        col_pc;
    logic [2:0]  op;

    // base and size select the region, any of eight subregions may be switched off
    always_comb begin
        size = att_word[`BTPG_ATT_SIZE_HI:`BTPG_ATT_SIZE_LO];
        mask = region_mask(size);
        sub  = (size >= `BTPG_SIZE_MIN) ? 3'((req_addr >> (size - 5'h02)) & 32'h7) : 3'h0;
        hit  = att_word[`BTPG_ATT_EN] && (size >= `BTPG_SIZE_MIN)
            && (((req_addr ^ addr_word) & ~mask) == 32'h0000_0000)
            && !addr_word[sub];
        op   = req_exec ? 3'h2 : (req_write ? 3'h1 : 3'h0);
        // unit flavour picks which master attributes matter
        unique case (mode)
            BTPG_MODE_MASTER: begin
                col_priv = req_priv;
                col_pc   = 1'b1;
            end
            BTPG_MODE_SHARED: begin
                col_priv = 1'b1;
                col_pc   = att_word[`BTPG_ATT_PC_LO + 32'(req_pc)];
            end
            default: begin
                col_priv = req_priv;
                col_pc   = att_word[`BTPG_ATT_PC_LO + 32'(req_pc)];
            end
        endcase
        permit = att_word[(col_priv ? `BTPG_ATT_PRIV_BASE : 0) + 32'(op)]
            && (req_secure || att_word[`BTPG_ATT_NS]) && col_pc;
    end
endmodule
`default_nettype wire

// [core/btpg_gate.sv]
// bus transfer protection gate: APB register file, structure scan, fault capture, interrupt
// assumes transfers and the APB master share one clock; inputs are synchronous to it
//
// What this block does
// - Structures are examined from index fifteen downward, one per cycle.
// - Each structure covers a region given by base address and size; only hits count.
// - Each structure holds read/write/execute, user/privileged, secure and context bits.
// - A transfer whose attributes satisfy the governing structure is granted.
// - A restricted transfer raises a fault and ends with a bus error.
// - Every transfer without an upstream stop has its address and attributes compared before the answer.
// - In shared-memory mode the context and secure bits decide, not the master.
// - In peripheral mode context, secure and privilege bits all decide.
// - Structures 0 to 3 have fixed regions; the rest are set by software.
// - A DMA transfer carries the attributes of the transfer that configured the channel.
// - Per-master mode uses the same region and attribute layout as the core unit.
// - Each structure sits on a 32-byte stride as an address word and attribute word.
// - Region size is a power of two from 256 B to 4 GB split into eight subregions.
// - A stop from an upstream unit ends the transfer before this unit evaluates it.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "btpg_params.svh"
module btpg_gate (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [31:0] paddr,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // transfer request
    input  wire logic        req_valid,
    input  wire logic [31:0] req_addr,
    input  wire logic        req_write,
    input  wire logic        req_exec,
    input  wire logic        req_priv,
    input  wire logic        req_secure,
    input  wire logic [3:0]  req_pc,
    input  wire logic        req_is_dma,
    input  wire logic        req_dma_cfg,
    input  wire logic        req_upstream_fault,
    output var  logic        req_ready,
    // transfer answer
    output var  logic        resp_valid,
    output var  logic        resp_grant,
    output var  logic        resp_bus_error,
    // interrupt
    output var  logic        irq
);
    import btpg_pkg::*;

    // fixed structures get a preset region; software can only change their attributes
    function automatic logic [31:0] fixed_addr(input logic [3:0] idx);
        return `BTPG_FIXED_BASE + (`BTPG_FIXED_STEP * 32'(idx));
    endfunction

    function automatic logic is_fixed(input logic [3:0] idx);
        return 32'(idx) < `BTPG_NUM_FIXED;
    endfunction

    // attribute word of a fixed structure has its size forced as well
    function automatic logic [31:0] eff_att(input logic [3:0] idx, input logic [31:0] att);
        logic [31:0] a;
        a = att;
        if (is_fixed(idx)) a[`BTPG_ATT_SIZE_HI:`BTPG_ATT_SIZE_LO] = `BTPG_FIXED_SIZE;
        return a;
    endfunction

    // ---------------- state ----------------
    btpg_state_t state_r, state_nxt;
    logic [3:0]  idx_r, idx_nxt;
    logic [31:0] cur_addr_r, cur_addr_nxt;
    logic        cur_write_r, cur_write_nxt;
    logic        cur_exec_r, cur_exec_nxt;
    logic        cur_priv_r, cur_priv_nxt;
    logic        cur_sec_r, cur_sec_nxt;
    logic [3:0]  cur_pc_r, cur_pc_nxt;
    logic        cur_cfg_r, cur_cfg_nxt;
    logic        dma_priv_r, dma_priv_nxt;
    logic        dma_sec_r, dma_sec_nxt;
    logic [3:0]  dma_pc_r, dma_pc_nxt;
    logic        ready_r, ready_nxt;
    logic        rv_r, rv_nxt;
    logic        rg_r, rg_nxt;
    logic        re_r, re_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic [1:0]  status_r, status_nxt;
    logic [1:0]  mask_r, mask_nxt;
    logic [31:0] faddr_r, faddr_nxt;
    logic [31:0] finfo_r, finfo_nxt;
    logic        irq_r, irq_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    // ---------------- structure storage and check ----------------
    logic [31:0] ev_addr_raw, ev_att_raw, bus_raw;
    logic [31:0] ev_addr_w, ev_att_w;
    logic        hit, permit;
    logic        is_struct, mem_wr;
    logic [3:0]  bus_idx;
    logic        apb_wr, apb_rd_cap;
    logic [1:0]  set_evt, clr_evt;
    logic        accept;

    assign bus_idx    = paddr[8:5];
    // a structure word lives at stride 32 with the address word at +0 and attributes at +4
    assign is_struct  = (paddr < `BTPG_STRUCT_LIMIT) && (paddr[4:3] == 2'b00)
        && (paddr[1:0] == 2'b00);
    assign apb_wr     = psel && penable && pready_r && pwrite;
    assign apb_rd_cap = psel && penable && !pready_r;
    // address words of fixed structures ignore software writes
    assign mem_wr     = apb_wr && is_struct && !(!paddr[2] && is_fixed(bus_idx));
    assign ev_addr_w  = is_fixed(idx_r) ? fixed_addr(idx_r) : ev_addr_raw;
    assign ev_att_w   = eff_att(idx_r, ev_att_raw);
    assign accept     = (state_r == BTPG_ST_IDLE) && ready_r && req_valid;

    btpg_struct_mem u_mem (
        .clock    (clock),
        .rst_n    (rst_n),
        .wr_en    (mem_wr),
        .wr_idx   (bus_idx),
        .wr_att   (paddr[2]),
        .wr_data  (pwdata),
        .ev_idx   (idx_nxt),
        .ev_addr  (ev_addr_raw),
        .ev_att   (ev_att_raw),
        .bus_idx  (bus_idx),
        .bus_att  (paddr[2]),
        .bus_data (bus_raw)
    );

    btpg_struct_check u_check (
        .addr_word  (ev_addr_w),
        .att_word   (ev_att_w),
        .req_addr   (cur_addr_r),
        .req_write  (cur_write_r),
        .req_exec   (cur_exec_r),
        .req_priv   (cur_priv_r),
        .req_secure (cur_sec_r),
        .req_pc     (cur_pc_r),
        .mode       (btpg_mode_t'(mode_r)),
        .hit        (hit),
        .permit     (permit)
    );

    // ---------------- transfer evaluation ----------------
    // one structure per cycle keeps the check to a single comparator at the cost of latency
    always_comb begin
        state_nxt     = state_r;
        idx_nxt       = idx_r;
        cur_addr_nxt  = cur_addr_r;
        cur_write_nxt = cur_write_r;
        cur_exec_nxt  = cur_exec_r;
        cur_priv_nxt  = cur_priv_r;
        cur_sec_nxt   = cur_sec_r;
        cur_pc_nxt    = cur_pc_r;
        cur_cfg_nxt   = cur_cfg_r;
        dma_priv_nxt  = dma_priv_r;
        dma_sec_nxt   = dma_sec_r;
        dma_pc_nxt    = dma_pc_r;
        rv_nxt        = 1'b0;
        rg_nxt        = 1'b0;
        re_nxt        = 1'b0;
        set_evt       = 2'b00;
        faddr_nxt     = faddr_r;
        finfo_nxt     = finfo_r;
        unique case (state_r)
            BTPG_ST_IDLE: begin
                if (accept) begin
                    cur_addr_nxt  = req_addr;
                    cur_write_nxt = req_write;
                    cur_exec_nxt  = req_exec;
                    // dma channels borrow the attributes latched at configuration
                    cur_priv_nxt  = req_is_dma ? dma_priv_r : req_priv;
                    cur_sec_nxt   = req_is_dma ? dma_sec_r : req_secure;
                    cur_pc_nxt    = req_is_dma ? dma_pc_r : req_pc;
                    cur_cfg_nxt   = req_dma_cfg;
                    if (req_upstream_fault) begin
                        // upstream stop wins: answer at once, no structure is read
                        rv_nxt     = 1'b1;
                        re_nxt     = 1'b1;
                        set_evt[`BTPG_EVT_UPSTREAM] = 1'b1;
                    end else begin
                        state_nxt = BTPG_ST_SCAN;
                        idx_nxt   = `BTPG_TOP_IDX;
                    end
                end
            end
            BTPG_ST_SCAN: begin
                if (hit) begin
                    // first hit from the top decides; lower structures are skipped
                    state_nxt = BTPG_ST_IDLE;
                    rv_nxt    = 1'b1;
                    rg_nxt    = permit;
                    re_nxt    = !permit;
                    if (!permit) begin
                        set_evt[`BTPG_EVT_DENY] = 1'b1;
                        faddr_nxt = cur_addr_r;
                        finfo_nxt = {16'h0000, idx_r, 3'b000, cur_write_r, cur_exec_r,
                            cur_priv_r, cur_sec_r, 1'b0, cur_pc_r};
                    end
                end else if (idx_r == 4'h0) begin
                    // no structure covers the address: the transfer passes
                    state_nxt = BTPG_ST_IDLE;
                    rv_nxt    = 1'b1;
                    rg_nxt    = 1'b1;
                end else begin
                    idx_nxt = idx_r - 4'h1;
                end
                if (rv_nxt && rg_nxt && cur_cfg_r) begin
                    // granted channel set-up: remember who programmed the channel
                    dma_priv_nxt = cur_priv_r;
                    dma_sec_nxt  = cur_sec_r;
                    dma_pc_nxt   = cur_pc_r;
                end
            end
            default: state_nxt = BTPG_ST_IDLE;
        endcase
        ready_nxt = (state_nxt == BTPG_ST_IDLE);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= BTPG_ST_IDLE;
            idx_r       <= 4'h0;
            cur_addr_r  <= 32'h0000_0000;
            cur_write_r <= 1'b0;
            cur_exec_r  <= 1'b0;
            cur_priv_r  <= 1'b0;
            cur_sec_r   <= 1'b0;
            cur_pc_r    <= 4'h0;
            cur_cfg_r   <= 1'b0;
            dma_priv_r  <= 1'b0;
            dma_sec_r   <= 1'b0;
            dma_pc_r    <= 4'h0;
            ready_r     <= 1'b1;
            rv_r        <= 1'b0;
            rg_r        <= 1'b0;
            re_r        <= 1'b0;
            faddr_r     <= 32'h0000_0000;
            finfo_r     <= 32'h0000_0000;
        end else begin
            state_r     <= state_nxt;
            idx_r       <= idx_nxt;
            cur_addr_r  <= cur_addr_nxt;
            cur_write_r <= cur_write_nxt;
            cur_exec_r  <= cur_exec_nxt;
            cur_priv_r  <= cur_priv_nxt;
            cur_sec_r   <= cur_sec_nxt;
            cur_pc_r    <= cur_pc_nxt;
            cur_cfg_r   <= cur_cfg_nxt;
            dma_priv_r  <= dma_priv_nxt;
            dma_sec_r   <= dma_sec_nxt;
            dma_pc_r    <= dma_pc_nxt;
            ready_r     <= ready_nxt;
            rv_r        <= rv_nxt;
            rg_r        <= rg_nxt;
            re_r        <= re_nxt;
            faddr_r     <= faddr_nxt;
            finfo_r     <= finfo_nxt;
        end
    end

    // ---------------- apb registers and interrupt ----------------
    // one wait state: read data is registered in the first access cycle
    always_comb begin
        mode_nxt    = mode_r;
        mask_nxt    = mask_r;
        clr_evt     = 2'b00;
        pready_nxt  = psel && penable && !pready_r;
        pslverr_nxt = pslverr_r;
        prdata_nxt  = prdata_r;
        if (apb_wr) begin
            unique case (paddr)
                `BTPG_OFS_CTRL:   mode_nxt = pwdata[1:0];
                `BTPG_OFS_STATUS: clr_evt  = pwdata[1:0];
                `BTPG_OFS_MASK:   mask_nxt = pwdata[1:0];
                default:          mode_nxt = mode_r;
            endcase
        end
        if (apb_rd_cap) begin
            pslverr_nxt = 1'b0;
            if (is_struct) begin
                prdata_nxt = paddr[2] ? eff_att(bus_idx, bus_raw)
                    : (is_fixed(bus_idx) ? fixed_addr(bus_idx) : bus_raw);
            end else begin
                unique case (paddr)
                    `BTPG_OFS_CTRL:       prdata_nxt = {30'h0, mode_r};
                    `BTPG_OFS_STATUS:     prdata_nxt = {30'h0, status_r};
                    `BTPG_OFS_MASK:       prdata_nxt = {30'h0, mask_r};
                    `BTPG_OFS_FAULT_ADDR: prdata_nxt = faddr_r;
                    `BTPG_OFS_FAULT_INFO: prdata_nxt = finfo_r;
                    default: begin
                        prdata_nxt  = 32'h0000_0000;
                        pslverr_nxt = 1'b1;
                    end
                endcase
            end
        end
        // a new event in the clearing cycle survives the clear
        status_nxt = (status_r & ~clr_evt) | set_evt;
        irq_nxt    = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r    <= `BTPG_CTRL_RST;
            mask_r    <= 2'b00;
            status_r  <= 2'b00;
            irq_r     <= 1'b0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            mode_r    <= mode_nxt;
            mask_r    <= mask_nxt;
            status_r  <= status_nxt;
            irq_r     <= irq_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // outputs straight from flip-flops
    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign req_ready      = ready_r;
    assign resp_valid     = rv_r;
    assign resp_grant     = rg_r;
    assign resp_bus_error = re_r;
    assign irq            = irq_r;

    // ---------------- checks ----------------
    a_verdict_exclusive: assert property (@(posedge clock) disable iff (!rst_n)
        resp_valid |-> (resp_grant != resp_bus_error))
        else $error("answer is both or neither grant and error");

    a_scan_from_top: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && !req_upstream_fault) |=> (state_r == BTPG_ST_SCAN) && (idx_r == 4'hF))
        else $error("scan did not start at structure fifteen");

    a_scan_counts_down: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == BTPG_ST_SCAN && !hit && idx_r != 4'h0)
            |=> (state_r == BTPG_ST_SCAN) && (idx_r == $past(idx_r) - 4'h1))
        else $error("scan index did not step down by one");

    a_upstream_first: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && req_upstream_fault)
            |=> resp_valid && resp_bus_error && status_r[1] && state_r == BTPG_ST_IDLE)
        else $error("upstream stop not answered at once");

    a_deny_sets_fault: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == BTPG_ST_SCAN && hit && !permit)
            |=> resp_bus_error && status_r[0] && (faddr_r == $past(cur_addr_r)))
        else $error("denied transfer left no fault record");

    a_hit_decides: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == BTPG_ST_SCAN && hit) |=> (state_r == BTPG_ST_IDLE) && resp_valid
            && (resp_grant == $past(permit)))
        else $error("matching structure did not decide the transfer");

    a_answer_bound: assert property (@(posedge clock) disable iff (!rst_n)
        (accept && !req_upstream_fault) |-> ##[2:17] resp_valid)
        else $error("transfer not answered within seventeen cycles");

    a_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
        irq == |(status_r & mask_r))
        else $error("interrupt disagrees with status and mask");
endmodule
`default_nettype wire

// [testbench/btpg_master_model.sv]
// bus master model: issues one transfer at a time and returns its answer
// assumes the gate's request and answer handshake on the shared clock
`timescale 1ns/1ps
`default_nettype none
module btpg_master_model (
    // clock
    input  wire logic        clock,
    // request; req_f is exec, dma_cfg, is_dma, upstream, write, priv, secure
    output var  logic        req_valid,
    output var  logic [31:0] req_addr,
    output var  logic [6:0]  req_f,
    output var  logic [3:0]  req_pc,
    // answer
    input  wire logic        req_ready,
    input  wire logic        resp_valid,
    input  wire logic        resp_grant,
    input  wire logic        resp_bus_error
);
    // idle request lines at time zero
    initial begin
        req_valid = 1'b0;
        req_addr  = 32'h0;
        req_f     = 7'h00;
        req_pc    = 4'h0;
    end
    // attributes ride with every transfer, held until taken
    task automatic run(input logic [31:0] a, input logic [6:0] f, input logic [3:0] pc,
                       output logic err, output logic ok);
        int i;
        err = 1'bx;
        ok = 1'bx;
        i = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req_addr  <= a;
        req_f     <= f;
        req_pc    <= pc;
        do begin @(posedge clock); i++; end while (req_ready !== 1'b1 && i < 40);
        // released address and flag lines show the inverse so a stale value is never reused
        req_valid <= 1'b0;
        req_addr  <= ~a;
        req_f     <= ~f;
        do begin @(posedge clock); i++; end while (resp_valid !== 1'b1 && i < 80);
        if (resp_valid === 1'b1) begin
            err = resp_bus_error;
            ok = resp_grant;
        end
    endtask
endmodule
`default_nettype wire

// [testbench/btpg_gate_tb.sv]
// self-checking bench for the protection gate: apb set-up, transfer table, irq
// assumes the master model drives the transfer port; exec rides in the top flag bit
`timescale 1ns/1ps
`default_nettype none
module btpg_gate_tb;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        ready, rv, rg, re, e, gr, g;
    logic [31:0] paddr, pwdata, prdata, ra, rd;
    logic [6:0]  rf;
    logic [3:0]  rpc;
    int          n_fail, n_checks;
    btpg_master_model i_mst (.clock(clock), .req_valid(rv), .req_addr(ra), .req_f(rf),
        .req_pc(rpc), .req_ready(ready), .resp_valid(rg), .resp_grant(gr), .resp_bus_error(re));
    btpg_gate i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(rv), .req_addr(ra), .req_write(rf[2]), .req_exec(rf[6]),
        .req_priv(rf[1]), .req_secure(rf[0]), .req_pc(rpc), .req_is_dma(rf[4]),
        .req_dma_cfg(rf[5]), .req_upstream_fault(rf[3]), .req_ready(ready),
        .resp_valid(rg), .resp_grant(gr), .resp_bus_error(re), .irq(irq));
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin @(posedge clock); i++; end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin n_fail++; results(); end
    endtask
    // one transfer through the model, answer compared with the expected bus error
    task automatic t(input logic [31:0] a, input logic [6:0] f, input logic [3:0] pc,
                     input logic x);
        i_mst.run(a, f, pc, e, g);
        chk({30'h0, g, e}, {30'h0, ~x, x});
        if (e === 1'bx) results();
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, n_fail, n_checks} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, 32'h200, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 32'h300, 32'h0);
        chk({e, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 32'h0, 32'h1234_5600);
        apb(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h4000_0000);
        apb(1'b0, 32'h4, 32'h0);
        chk({27'h0, rd[28:24]}, 32'hB);
        apb(1'b1, 32'h1C0, 32'h1000_0000);
        apb(1'b1, 32'h1C4, 32'h87FF_FF7F);
        apb(1'b1, 32'h1E0, 32'h1000_0002);
        apb(1'b1, 32'h1E4, 32'h87FF_FF01);
        apb(1'b1, 32'h208, 32'h3);
        t(32'h1000_0010, 7'h01, 4'h0, 1'b0);
        t(32'h1000_0010, 7'h05, 4'h0, 1'b1);
        t(32'h1000_0010, 7'h00, 4'h0, 1'b1);
        t(32'h1000_0030, 7'h05, 4'h0, 1'b0);
        t(32'h1000_0100, 7'h05, 4'h0, 1'b0);
        t(32'h1000_0010, 7'h03, 4'h0, 1'b1);
        t(32'h1000_0030, 7'h41, 4'h0, 1'b0);
        t(32'h1000_0010, 7'h41, 4'h0, 1'b1);
        t(32'h1000_0010, 7'h09, 4'h0, 1'b1);
        apb(1'b0, 32'h204, 32'h0);
        chk(rd, 32'h3);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, 32'h20C, 32'h0);
        chk(rd, 32'h1000_0010);
        apb(1'b0, 32'h210, 32'h0);
        chk(rd, 32'h0000_F0A0);
        apb(1'b1, 32'h204, 32'h3);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 32'h1E4, 32'h8700_0101);
        t(32'h1000_0010, 7'h01, 4'h1, 1'b1);
        apb(1'b1, 32'h200, 32'h0);
        t(32'h1000_0010, 7'h01, 4'h1, 1'b0);
        apb(1'b1, 32'h200, 32'h1);
        t(32'h1000_0010, 7'h01, 4'h0, 1'b1);
        apb(1'b1, 32'h200, 32'h2);
        apb(1'b1, 32'h1E4, 32'h87FF_FF01);
        t(32'h2000_0000, 7'h21, 4'h0, 1'b0);
        t(32'h1000_0010, 7'h10, 4'h5, 1'b0);
        results();
    end
endmodule
`default_nettype wire
